// ==== logic/erfp_defines.svh ====
// Register offsets, field positions and reset values of the request block
`ifndef ERFP_DEFINES_SVH
`define ERFP_DEFINES_SVH

// Byte offsets of the word registers
`define ERFP_ADDR_PRIO_A   8'h00
`define ERFP_ADDR_PRIO_B   8'h04
`define ERFP_ADDR_PRIO_C   8'h08
`define ERFP_ADDR_PRIO_D   8'h0c
`define ERFP_ADDR_PRIO_E   8'h10
`define ERFP_ADDR_FLAGS    8'h14
`define ERFP_ADDR_SENSE    8'h18
`define ERFP_ADDR_EVT_STAT 8'h1c
`define ERFP_ADDR_EVT_MASK 8'h20

// Field geometry
`define ERFP_NUM_PINS      3
`define ERFP_NUM_PRIO      5
`define ERFP_PRIO_FLD_W    4
`define ERFP_SENSE_FLD_W   2
`define ERFP_SYNC_STAGES   2

// Reset values
`define ERFP_RST_PRIO      16'h0000
`define ERFP_RST_FLAGS     3'h0
`define ERFP_RST_SENSE     6'h00
`define ERFP_RST_EVT       3'h0

`endif

// ==== logic/erfp_pkg.sv ====
// Types shared by the request flag and priority block
package erfp_pkg;

   typedef enum logic [1:0] {
      ERFP_SENSE_LOW  = 2'h0,
      ERFP_SENSE_FALL = 2'h1,
      ERFP_SENSE_RISE = 2'h2,
      ERFP_SENSE_BOTH = 2'h3
   } erfp_sense_t;

   typedef logic [3:0]  erfp_level_t;
   typedef logic [15:0] erfp_word_t;

endpackage

// ==== logic/erfp_prio_bank.sv ====
// Bank of priority words with registered read data
`include "erfp_defines.svh"

module erfp_prio_bank #(
   parameter int WORDS = 5,
   parameter int DW    = 16,
   parameter int IW    = 3
) (
   // Clock and reset
   input  wire logic                clk_sys_i,
   input  wire logic                srst_i,
   // Write port
   input  wire logic                wr_en_i,
   input  wire logic [IW-1:0]       wr_idx_i,
   input  wire logic [DW-1:0]       wr_data_i,
   // Read port
   input  wire logic [IW-1:0]       rd_idx_i,
   output logic      [DW-1:0]       rd_data_o,
   // All words for the decode logic
   output logic      [WORDS*DW-1:0] words_o
);

   logic [DW-1:0] mem_r [WORDS];

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         for (int i = 0; i < WORDS; i++) begin
            mem_r[i] <= DW'(`ERFP_RST_PRIO);
         end
      end else if (wr_en_i && (int'(wr_idx_i) < WORDS)) begin
         mem_r[wr_idx_i] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rd_data_o <= '0;
      end else if (int'(rd_idx_i) < WORDS) begin
         rd_data_o <= mem_r[rd_idx_i];
      end else begin
         rd_data_o <= '0;
      end
   end

   always_comb begin
      for (int i = 0; i < WORDS; i++) begin
         words_o[i*DW +: DW] = mem_r[i];
      end
   end

endmodule

// ==== logic/erfp_top.sv ====
// External request flags, priority registers and request arbitration
//
// What this block does
// - Level mode: flag is 1 while pin low
// - Level mode: flag clears when pin high
// - Edge mode: selected edge sets flag, held
// - Edge mode: write 0 after read 1 clears
// - Edge mode: CPU acceptance clears the flag
// - Three flags, bits 2..0, reset to 0
// - Five read/write 16-bit priority registers
// - Four 4-bit priority fields per register
// - Field is unsigned level, 0 lowest, 15 highest
// - All priority bits reset to zero
// - Level 0 means masked, never requested
// - Sense bits pick low, fall, rise, both
`include "erfp_defines.svh"

module erfp_top
   import erfp_pkg::*;
#(
   parameter int NPINS = `ERFP_NUM_PINS,
   parameter int NPRIO = `ERFP_NUM_PRIO
) (
   // Clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             srst_i,
   // Register port
   input  wire logic [7:0]       addr_i,
   input  wire logic [15:0]      wr_data_i,
   input  wire logic             wr_en_i,
   input  wire logic             rd_en_i,
   output logic      [15:0]      rd_data_o,
   // External request pins, asynchronous
   input  wire logic [NPINS-1:0] ext_req_pin_i,
   // CPU acceptance of a pin's request
   input  wire logic             accept_i,
   input  wire logic [1:0]       accept_pin_i,
   // Request towards the CPU
   output logic                  req_valid_o,
   output logic      [3:0]       req_level_o,
   output logic      [1:0]       req_pin_o,
   // Interrupt line
   output logic                  irq_o
);

   //////////////////////////////////////////////////////////////////////
   // Functions

   // Priority field of a pin: pin n uses field 3-n of the first word
   function automatic erfp_level_t pin_level(
      input logic [NPRIO*16-1:0] words,
      input int                  pin
   );
      int lsb;
      lsb = 16 - `ERFP_PRIO_FLD_W * (pin + 1);
      return words[lsb +: `ERFP_PRIO_FLD_W];
   endfunction

   // Selected edge between previous and current pin sample
   function automatic logic edge_hit(
      input erfp_sense_t sense,
      input logic        prev,
      input logic        cur
   );
      logic res;
      res = 1'b0;
      case (sense)
         ERFP_SENSE_FALL: res = prev & ~cur;
         ERFP_SENSE_RISE: res = ~prev & cur;
         ERFP_SENSE_BOTH: res = prev ^ cur;
         default:         res = 1'b0;
      endcase
      return res;
   endfunction

   //////////////////////////////////////////////////////////////////////
   // Declarations

   logic [NPINS-1:0]   pin_s1_r;
   logic [NPINS-1:0]   pin_s2_r;
   logic [NPINS-1:0]   pin_prev_r;
   logic [NPINS-1:0]   flag_r;
   logic [NPINS-1:0]   flag_nxt;
   logic [NPINS-1:0]   rd_seen_r;
   logic [NPINS-1:0]   rd_seen_nxt;
   logic [NPINS*2-1:0] sense_r;
   logic [NPINS-1:0]   evt_stat_r;
   logic [NPINS-1:0]   evt_stat_nxt;
   logic [NPINS-1:0]   evt_mask_r;
   logic [15:0]        loc_rdata_r;
   logic               bank_sel_r;
   logic [15:0]        bank_rdata;
   logic [NPRIO*16-1:0] prio_words;
   logic               best_valid_r;
   logic [3:0]         best_level_r;
   logic [1:0]         best_pin_r;
   logic               best_valid_nxt;
   logic [3:0]         best_level_nxt;
   logic [1:0]         best_pin_nxt;
   logic [NPINS-1:0]   sw_clr;
   logic [NPINS-1:0]   acc_clr;
   logic [NPINS-1:0]   edge_set;
   logic [NPINS-1:0]   level_mode;
   logic [15:0]        loc_rdata_nxt;

   //////////////////////////////////////////////////////////////////////
   // Address decode

   wire       aligned    = (addr_i[1:0] == 2'h0);
   wire [2:0] prio_idx   = addr_i[4:2];
   wire       sel_prio   = aligned && (addr_i < `ERFP_ADDR_FLAGS);
   wire       sel_flags  = (addr_i == `ERFP_ADDR_FLAGS);
   wire       sel_sense  = (addr_i == `ERFP_ADDR_SENSE);
   wire       sel_estat  = (addr_i == `ERFP_ADDR_EVT_STAT);
   wire       sel_emask  = (addr_i == `ERFP_ADDR_EVT_MASK);
   wire       prio_wr    = wr_en_i && sel_prio;
   wire       flags_wr   = wr_en_i && sel_flags;
   wire       flags_rd   = rd_en_i && sel_flags;
   wire       sense_wr   = wr_en_i && sel_sense;
   wire       estat_wr   = wr_en_i && sel_estat;
   wire       emask_wr   = wr_en_i && sel_emask;

   //////////////////////////////////////////////////////////////////////
   // Priority bank

   // Words are plain storage; unused fields are left as software wrote
   // them, which should be zero
   erfp_prio_bank #(
      .WORDS (NPRIO),
      .DW    (16),
      .IW    (3)
   ) u_prio_bank (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .wr_en_i   (prio_wr),
      .wr_idx_i  (prio_idx),
      .wr_data_i (wr_data_i),
      .rd_idx_i  (prio_idx),
      .rd_data_o (bank_rdata),
      .words_o   (prio_words)
   );

   //////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         pin_s1_r   <= '1;
         pin_s2_r   <= '1;
         pin_prev_r <= '1;
      end else begin
         pin_s1_r   <= ext_req_pin_i;
         pin_s2_r   <= pin_s1_r;
         pin_prev_r <= pin_s2_r;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Flag update

   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         level_mode[i] = (erfp_sense_t'(sense_r[2*i +: 2])
                          == ERFP_SENSE_LOW);
         edge_set[i]   = edge_hit(erfp_sense_t'(sense_r[2*i +: 2]),
                                  pin_prev_r[i], pin_s2_r[i]);
         sw_clr[i]     = flags_wr && !wr_data_i[i]
                         && rd_seen_r[i];
         acc_clr[i]    = accept_i && (int'(accept_pin_i) == i);
      end
   end

   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         if (level_mode[i]) begin
            // Flag mirrors the pin: set while low, clear when high
            flag_nxt[i] = ~pin_s2_r[i];
         end else begin
            // Set has priority over either clear
            flag_nxt[i] = edge_set[i]
                          | (flag_r[i] & ~(sw_clr[i] | acc_clr[i]));
         end
      end
   end

   // Remember which flags were read as 1 before a clearing write
   always_comb begin
      if (flags_wr) begin
         rd_seen_nxt = '0;
      end else if (flags_rd) begin
         rd_seen_nxt = flag_r;
      end else begin
         rd_seen_nxt = rd_seen_r & flag_r;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         flag_r    <= `ERFP_RST_FLAGS;
         rd_seen_r <= '0;
      end else begin
         flag_r    <= flag_nxt;
         rd_seen_r <= rd_seen_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Sense select and event status

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         sense_r <= `ERFP_RST_SENSE;
      end else if (sense_wr) begin
         sense_r <= wr_data_i[NPINS*2-1:0];
      end
   end

   // New flag rises set sticky bits; a set in the clear cycle wins
   always_comb begin
      evt_stat_nxt = evt_stat_r;
      if (estat_wr) begin
         evt_stat_nxt = evt_stat_r & ~wr_data_i[NPINS-1:0];
      end
      evt_stat_nxt = evt_stat_nxt | (flag_nxt & ~flag_r);
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         evt_stat_r <= `ERFP_RST_EVT;
         evt_mask_r <= `ERFP_RST_EVT;
      end else begin
         evt_stat_r <= evt_stat_nxt;
         if (emask_wr) begin
            evt_mask_r <= wr_data_i[NPINS-1:0];
         end
      end
   end

   assign irq_o = |(evt_stat_r & evt_mask_r);

   //////////////////////////////////////////////////////////////////////
   // Request arbitration

   // Highest level wins, lower pin number on a tie; level 0 is masked
   always_comb begin
      best_valid_nxt = 1'b0;
      best_level_nxt = 4'h0;
      best_pin_nxt   = 2'h0;
      for (int i = 0; i < NPINS; i++) begin
         if (flag_r[i] && (pin_level(prio_words, i) != 4'h0)
             && (pin_level(prio_words, i) > best_level_nxt)) begin
            best_valid_nxt = 1'b1;
            best_level_nxt = pin_level(prio_words, i);
            best_pin_nxt   = 2'(i);
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         best_valid_r <= 1'b0;
         best_level_r <= 4'h0;
         best_pin_r   <= 2'h0;
      end else begin
         best_valid_r <= best_valid_nxt;
         best_level_r <= best_level_nxt;
         best_pin_r   <= best_pin_nxt;
      end
   end

   assign req_valid_o = best_valid_r;
   assign req_level_o = best_level_r;
   assign req_pin_o   = best_pin_r;

   //////////////////////////////////////////////////////////////////////
   // Read data

   always_comb begin
      loc_rdata_nxt = 16'h0000;
      if (sel_flags) begin
         loc_rdata_nxt[NPINS-1:0] = flag_r;
      end else if (sel_sense) begin
         loc_rdata_nxt[NPINS*2-1:0] = sense_r;
      end else if (sel_estat) begin
         loc_rdata_nxt[NPINS-1:0] = evt_stat_r;
      end else if (sel_emask) begin
         loc_rdata_nxt[NPINS-1:0] = evt_mask_r;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         loc_rdata_r <= 16'h0000;
         bank_sel_r  <= 1'b0;
      end else if (rd_en_i) begin
         loc_rdata_r <= loc_rdata_nxt;
         bank_sel_r  <= sel_prio;
      end else begin
         loc_rdata_r <= 16'h0000;
         bank_sel_r  <= 1'b0;
      end
   end

   assign rd_data_o = bank_sel_r ? bank_rdata : loc_rdata_r;

endmodule

// ==== verification/erfp_cpu_model.sv ====
// CPU acceptance model facing the request port
module erfp_cpu_model (
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       srst_i,
   // Control and request
   input  wire logic       en_i,
   input  wire logic       req_i,
   input  wire logic [1:0] pin_i,
   // Acceptance
   output logic            acc_o,
   output logic      [1:0] acc_pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_r;
   // Takes the winning pin after a few cycles of pending request
   always_ff @(posedge clk_sys_i) begin
      acc_o <= 1'b0;
      if (srst_i) begin
         wait_r    <= 2'h0;
         acc_pin_o <= 2'h0;
      end else if (!en_i || !req_i) begin
         wait_r <= 2'h0;
      end else if (wait_r == 2'h3) begin
         acc_o     <= 1'b1;
         acc_pin_o <= pin_i;
         wait_r    <= 2'h0;
      end else begin
         wait_r <= wait_r + 2'h1;
      end
   end
endmodule

// ==== verification/erfp_top_asserts.sv ====
// Port-level assertions of the request flags and priority block
module erfp_top_asserts
   import erfp_pkg::*;
#(
   parameter int NPINS = 3,
   parameter int NPRIO = 5
) (
   // Clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             srst_i,
   // Register port
   input  wire logic [7:0]       addr_i,
   input  wire logic [15:0]      wr_data_i,
   input  wire logic             wr_en_i,
   input  wire logic             rd_en_i,
   input  wire logic [15:0]      rd_data_o,
   // Pins and acceptance
   input  wire logic [NPINS-1:0] ext_req_pin_i,
   input  wire logic             accept_i,
   input  wire logic [1:0]       accept_pin_i,
   // Request and interrupt
   input  wire logic             req_valid_o,
   input  wire logic [3:0]       req_level_o,
   input  wire logic [1:0]       req_pin_o,
   input  wire logic             irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (srst_i);
   logic [15:0] last_w [NPRIO];
   wire         prio_hit = addr_i <= 8'h10 && addr_i[1:0] == 2'h0;
   ////////////////////////////////////////////////////////////////////////
   // Shadow of the priority words as written over the bus
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         last_w <= '{default: 16'h0000};
      end else if (wr_en_i && prio_hit) begin
         last_w[addr_i[4:2]] <= wr_data_i;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   a_reset_quiet: assert property (disable iff (1'b0)
      srst_i |=> rd_data_o == 16'h0 && !irq_o && !req_valid_o)
      else $error("outputs not quiet after reset");
   a_rd_idle: assert property (!$past(rd_en_i) |-> rd_data_o == 16'h0)
      else $error("read data outside read window");
   a_prio_read: assert property (rd_en_i && prio_hit
      |=> rd_data_o == last_w[$past(addr_i[4:2])])
      else $error("priority word read back wrong");
   a_unmapped_rd: assert property (rd_en_i && addr_i > 8'h20
      |=> rd_data_o == 16'h0)
      else $error("unmapped read not zero");
   a_flag_width: assert property (rd_en_i && addr_i == 8'h14
      |=> rd_data_o[15:3] == 13'h0)
      else $error("flag word upper bits set");
   a_level_masked: assert property (req_valid_o |-> req_level_o != 4'h0)
      else $error("request at level zero");
   a_idle_zero: assert property (!req_valid_o
      |-> req_level_o == 4'h0 && req_pin_o == 2'h0)
      else $error("idle request fields not zero");
   a_level_field: assert property (req_valid_o && !$past(wr_en_i)
      |-> req_level_o == last_w[0][12 - 4 * req_pin_o +: 4])
      else $error("request level differs from field");
   c_irq: cover property ($rose(irq_o));
   c_req: cover property ($rose(req_valid_o));
   c_accept: cover property (accept_i && req_valid_o);
endmodule

bind erfp_top erfp_top_asserts #(.NPINS(NPINS), .NPRIO(NPRIO)) u_asserts (
   .clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i),
   .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
   .rd_data_o(rd_data_o), .ext_req_pin_i(ext_req_pin_i),
   .accept_i(accept_i), .accept_pin_i(accept_pin_i),
   .req_valid_o(req_valid_o), .req_level_o(req_level_o),
   .req_pin_o(req_pin_o), .irq_o(irq_o));

// ==== verification/erfp_top_bench.sv ====
// Self-checking bench of the request flags and priority block
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("Error %0t: got %h expected %h", $time, g, e); end end

module erfp_top_bench
   import erfp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] PAT [5] = '{16'h5a30, 16'hffff, 16'h0001,
                                       16'h8421, 16'hf0f0};
   logic        clk_sys_i = 1'b0;
   logic        srst_i    = 1'b1;
   logic [7:0]  addr_i    = 8'h00;
   logic [15:0] wr_data_i = 16'h0000;
   logic        wr_en_i   = 1'b0;
   logic        rd_en_i   = 1'b0;
   logic [2:0]  pins      = 3'h7;
   logic        cpu_en    = 1'b0;
   logic [15:0] rd_data_o;
   logic        req_valid_o, accept_i, irq_o;
   logic [3:0]  req_level_o;
   logic [1:0]  req_pin_o, accept_pin_i;
   int          err_count  = 0;
   int          n_compared = 0;

   always #10 clk_sys_i = ~clk_sys_i;

   erfp_top dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
      .rd_data_o(rd_data_o), .ext_req_pin_i(pins), .accept_i(accept_i),
      .accept_pin_i(accept_pin_i), .req_valid_o(req_valid_o),
      .req_level_o(req_level_o), .req_pin_o(req_pin_o), .irq_o(irq_o));
   erfp_cpu_model cpu (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
      .en_i(cpu_en), .req_i(req_valid_o), .pin_i(req_pin_o),
      .acc_o(accept_i), .acc_pin_o(accept_pin_i));
   ////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (err_count == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      addr_i    <= a;
      wr_data_i <= d;
      wr_en_i   <= 1'b1;
      @(posedge clk_sys_i);
      wr_en_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk_sys_i);
      addr_i  <= a;
      rd_en_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_en_i <= 1'b0;
      #1 `CHK(rd_data_o, e)
   endtask
   // Pin change, then enough edges for flag and request to settle
   task automatic pin(input logic [2:0] v);
      @(posedge clk_sys_i);
      pins <= v;
      repeat (5) @(posedge clk_sys_i);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4000) @(posedge clk_sys_i);
      err_count++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      for (int i = 0; i <= 9; i++) rd(8'(4 * i), 16'h0000);
      for (int i = 0; i < 5; i++) wr(8'(4 * i), PAT[i]);
      for (int i = 0; i < 5; i++) rd(8'(4 * i), PAT[i]);
      pin(3'h6);
      rd(8'h14, 16'h0001);
      `CHK({req_valid_o, req_pin_o, req_level_o}, 7'h45)
      wr(8'h14, 16'h0000);
      rd(8'h14, 16'h0001);
      pin(3'h0);
      `CHK({req_valid_o, req_pin_o, req_level_o}, 7'h5a)
      pin(3'h7);
      rd(8'h14, 16'h0000);
      `CHK(req_valid_o, 1'b0)
      wr(8'h18, {10'h0, ERFP_SENSE_FALL, ERFP_SENSE_RISE, ERFP_SENSE_BOTH});
      pin(3'h5);
      pin(3'h1);
      rd(8'h14, 16'h0004);
      wr(8'h14, 16'h0004);
      pin(3'h3);
      wr(8'h14, 16'h0000);
      rd(8'h14, 16'h0006);
      wr(8'h14, 16'h0004);
      rd(8'h14, 16'h0004);
      pin(3'h2);
      cpu_en <= 1'b1;
      repeat (24) @(posedge clk_sys_i);
      cpu_en <= 1'b0;
      rd(8'h14, 16'h0000);
      `CHK(req_valid_o, 1'b0)
      pin(3'h3);
      rd(8'h14, 16'h0001);
      rd(8'h1c, 16'h0007);
      `CHK(irq_o, 1'b0)
      wr(8'h20, 16'h0001);
      `CHK(irq_o, 1'b1)
      wr(8'h1c, 16'h0001);
      `CHK(irq_o, 1'b0)
      rd(8'h1c, 16'h0006);
      close_out();
   end
endmodule
